// [dpc_checker_assertions.sv]
// handshake and coding checks on the pixel compression encoder ports
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// checker
// ----------------------------------------
module dpc_checker #(
	parameter PIX_W  = 12,
	parameter WORD_W = 8
) (
	input wire logic              clock,
	input wire logic              rst,
	input wire logic [1:0]        mode,
	input wire logic              in_valid,
	input wire logic              in_ready,
	input wire logic [PIX_W-1:0]  in_pixel,
	input wire logic [PIX_W-1:0]  in_pred,
	input wire logic              in_unpredicted,
	input wire logic              out_valid,
	input wire logic              out_ready,
	input wire logic [WORD_W-1:0] out_word,
	input wire logic [1:0]        out_mode
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// accepted pixel and the upper pcm bound, widened so it cannot wrap
	wire logic        take;
	wire logic [12:0] pred_hi;
	assign take = in_valid & in_ready;
	assign pred_hi = {1'b0, in_pred} + 13'h0168;

	ready_rule_a: assert property (in_ready == (!out_valid || out_ready))
		else $error("in_ready disagrees with output handshake");
	answer_next_a: assert property (take |=> out_valid && out_mode == $past(mode))
		else $error("accepted pixel gave no word next cycle");
	hold_stall_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
		else $error("word changed while stalled");
	drain_idle_a: assert property (out_valid && out_ready && !in_valid |=> !out_valid)
		else $error("word repeated after being taken");
	raw_low_a: assert property (take && in_unpredicted && mode == 2'h0 |=>
		out_word == (($past(in_pixel[9:4]) == 6'h00) ? 8'h01 : {2'h0, $past(in_pixel[9:4])}))
		else $error("unpredicted 10-bit word wrong");
	raw_high_a: assert property (take && in_unpredicted && mode == 2'h2 |=>
		out_word == (($past(in_pixel[11:5]) == 7'h00) ? 8'h01 : {1'h0, $past(in_pixel[11:5])}))
		else $error("unpredicted 12-7-12 word wrong");
	zero_diff_a: assert property (take && !in_unpredicted && mode == 2'h0 &&
		in_pixel[9:0] == in_pred[9:0] |=> out_word == 8'h01)
		else $error("zero difference not sent as negative zero");
	pcm_wide_a: assert property (take && !in_unpredicted && mode == 2'h1 &&
		{1'b0, in_pixel} >= pred_hi |=> out_word == {1'b1, $past(in_pixel[11:5])})
		else $error("12-8-12 pcm word wrong");
	reset_clear_a: assert property ($fell(rst) |-> !out_valid && out_word == 8'h00)
		else $error("outputs not cleared by reset");
endmodule

bind dpc_pixel_compressor dpc_checker #(.PIX_W(PIX_W), .WORD_W(WORD_W)) u_chk (
	.clock(clock), .rst(rst), .mode(mode), .in_valid(in_valid), .in_ready(in_ready),
	.in_pixel(in_pixel), .in_pred(in_pred), .in_unpredicted(in_unpredicted),
	.out_valid(out_valid), .out_ready(out_ready), .out_word(out_word), .out_mode(out_mode));
`default_nettype wire

// [dpc_consts.vh]
// constants shared by the pixel compression encoder
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH

// ----------------------------------------------------------------
// scheme select codes
// ----------------------------------------------------------------
`define DPC_MODE_10_6_10 2'h0
`define DPC_MODE_12_8_12 2'h1
`define DPC_MODE_12_7_12 2'h2

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define DPC_PIX_W  12
`define DPC_WORD_W 8

// ----------------------------------------------------------------
// 10-6-10: thresholds, offsets, divisors, code words
// ----------------------------------------------------------------
`define DPC_A_TH1     12'h001
`define DPC_A_TH2     12'h003
`define DPC_A_TH3     12'h00B
`define DPC_A_TH4     12'h02B
`define DPC_A_TH5     12'h0AB
`define DPC_A_DIV3    12'h004
`define DPC_A_DIV4    12'h008
`define DPC_A_DIV5    12'h010
`define DPC_A_DIV_PCM 12'h020
`define DPC_A_DIV_RAW 12'h010
`define DPC_A_CW1     5'h00
`define DPC_A_CW2     5'h01
`define DPC_A_CW3     4'h1
`define DPC_A_CW4     3'h1
`define DPC_A_CW5     2'h1

// ----------------------------------------------------------------
// 12-8-12: thresholds, offsets, divisors, code words
// ----------------------------------------------------------------
`define DPC_B_TH1     12'h008
`define DPC_B_TH2     12'h028
`define DPC_B_TH3     12'h068
`define DPC_B_TH4     12'h0E8
`define DPC_B_TH5     12'h168
`define DPC_B_DIV2    12'h002
`define DPC_B_DIV3    12'h004
`define DPC_B_DIV4    12'h008
`define DPC_B_DIV5    12'h010
`define DPC_B_DIV_PCM 12'h020
`define DPC_B_DIV_RAW 12'h010
`define DPC_B_CW1     4'h0
`define DPC_B_CW2     3'h3
`define DPC_B_CW3     3'h2
`define DPC_B_CW4     3'h1
`define DPC_B_CW5     4'h1

// ----------------------------------------------------------------
// 12-7-12: thresholds, offsets, divisors, code words
// ----------------------------------------------------------------
`define DPC_C_TH1     12'h004
`define DPC_C_TH2     12'h00C
`define DPC_C_TH3     12'h01C
`define DPC_C_TH4     12'h05C
`define DPC_C_TH5     12'h0DC
`define DPC_C_TH6     12'h15C
`define DPC_C_DIV2    12'h002
`define DPC_C_DIV3    12'h004
`define DPC_C_DIV4    12'h008
`define DPC_C_DIV5    12'h010
`define DPC_C_DIV6    12'h020
`define DPC_C_DIV_PCM 12'h040
`define DPC_C_DIV_RAW 12'h020
`define DPC_C_CW1     4'h0
`define DPC_C_CW2     4'h1
`define DPC_C_CW3     4'h2
`define DPC_C_CW4     3'h2
`define DPC_C_CW5     3'h3
`define DPC_C_CW6     4'h3

// ----------------------------------------------------------------
// common fields
// ----------------------------------------------------------------
`define DPC_PCM_CW    1'h1
`define DPC_RAW_ZERO  12'h000
`define DPC_RAW_ONE   12'h001

`endif

// [dpc_diff_unit.v]
// prediction difference: magnitude and sign of original minus prediction
`timescale 1ns/10ps
`default_nettype none

module dpc_diff_unit #(
	parameter W = 12
) (
	input  wire [W-1:0] orig,
	input  wire [W-1:0] pred,
	output wire [W-1:0] abs_diff,
	output wire         neg,
	output wire         nonpos
);

	// ------------------------------------------------------------
	// signed difference
	// ------------------------------------------------------------
	// one extra bit keeps the sign; W-bit operands never overflow it
	wire [W:0] diff;
	wire [W:0] mag;

	assign diff     = {1'b0, orig} - {1'b0, pred};
	assign neg      = diff[W];
	assign mag      = neg ? (~diff + {{W{1'b0}}, 1'b1}) : diff;
	// largest magnitude is 2^W-1, so the top bit is always clear
	assign abs_diff = mag[W-1:0];
	assign nonpos   = neg | (diff == {(W+1){1'b0}});

endmodule

`default_nettype wire

// [dpc_pixel_compressor.v]
// pixel compression encoder for the 10-6-10, 12-8-12 and 12-7-12 schemes
//
// How it works
// - unpredicted pixel: scaled down, zero becomes one
// - 10-6-10 picks class from difference thresholds
// - 10-6-10 DPCM1: 00000 then sign always one
// - 10-6-10 DPCM2: 00001 then difference sign
// - 10-6-10 DPCM3: 0001, sign, (d-3)/4
// - 10-6-10 DPCM4: 001, sign, (d-11)/8
// - 10-6-10 DPCM5: 01, sign, (d-43)/16
// - 10-6-10 PCM: 1 then pixel/32
// - 12-8-12 picks class from difference thresholds
// - 12-8-12 DPCM1: 0000, nonpositive sign, d
// - 12-8-12 DPCM2: 011, sign, (d-8)/2
// - 12-8-12 DPCM3: 010, sign, (d-40)/4
// - 12-8-12 DPCM4: 001, sign, (d-104)/8
// - 12-8-12 DPCM5: 0001, sign, (d-232)/16
// - 12-8-12 PCM: 1 then pixel/32
// - 12-7-12 picks class from difference thresholds
// - 12-7-12 DPCM1: 0000, nonpositive sign, d
// - 12-7-12 DPCM2: 0001, sign, (d-4)/2
// - first pixel of line coded unpredicted
// - 12-7-12 PCM: 1 then pixel/64
`timescale 1ns/10ps
`default_nettype none
`include "dpc_consts.vh"

module dpc_pixel_compressor #(
	parameter PIX_W  = `DPC_PIX_W,
	parameter WORD_W = `DPC_WORD_W
) (
	input  wire              clock,
	input  wire              rst,
	input  wire [1:0]        mode,
	input  wire              in_valid,
	output wire              in_ready,
	input  wire [PIX_W-1:0]  in_pixel,
	input  wire [PIX_W-1:0]  in_pred,
	input  wire              in_unpredicted,
	output wire              out_valid,
	input  wire              out_ready,
	output wire [WORD_W-1:0] out_word,
	output wire [1:0]        out_mode
);

	// ------------------------------------------------------------
	// difference between pixel and prediction
	// ------------------------------------------------------------
	wire [PIX_W-1:0] abs_diff;
	wire             diff_neg;
	wire             diff_nonpos;

	// original minus prediction, sign kept apart from magnitude
	dpc_diff_unit #(
		.W(PIX_W)
	) u_diff (
		.orig     (in_pixel),
		.pred     (in_pred),
		.abs_diff (abs_diff),
		.neg      (diff_neg),
		.nonpos   (diff_nonpos)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// truncating scale of a magnitude after removing the class base
	function [11:0] scale;
		input [11:0] mag;
		input [11:0] base;
		input [11:0] div;
		begin
			scale = (mag - base) / div;
		end
	endfunction

	// plain scaled value for a pixel with no prediction
	function [11:0] raw_code;
		input [11:0] pix;
		input [11:0] div;
		reg   [11:0] q;
		begin
			q = pix / div;
			// an all-zero word is reserved, so zero goes out as one
			if (q == `DPC_RAW_ZERO) begin
				raw_code = `DPC_RAW_ONE;
			end else begin
				raw_code = q;
			end
		end
	endfunction

	// ------------------------------------------------------------
	// 10-6-10 coder, six bits in the low end of the word
	// ------------------------------------------------------------
	// words are packed code word first, then sign, then value
	function [7:0] code_a;
		input [11:0] mag;
		input        neg;
		input [11:0] pix;
		reg   [11:0] v;
		begin
			v = 12'h000;
			// classes tried from narrowest to widest
			if (mag < `DPC_A_TH1) begin
				// zero difference always sent as negative zero
				code_a = {2'h0, `DPC_A_CW1, 1'h1};
			end else if (mag < `DPC_A_TH2) begin
				code_a = {2'h0, `DPC_A_CW2, neg};
			end else if (mag < `DPC_A_TH3) begin
				v = scale(mag, `DPC_A_TH2, `DPC_A_DIV3);
				code_a = {2'h0, `DPC_A_CW3, neg, v[0]};
			end else if (mag < `DPC_A_TH4) begin
				v = scale(mag, `DPC_A_TH3, `DPC_A_DIV4);
				code_a = {2'h0, `DPC_A_CW4, neg, v[1:0]};
			end else if (mag < `DPC_A_TH5) begin
				v = scale(mag, `DPC_A_TH4, `DPC_A_DIV5);
				code_a = {2'h0, `DPC_A_CW5, neg, v[2:0]};
			end else begin
				// only the top bits of the pixel survive, no sign
				v = pix / `DPC_A_DIV_PCM;
				code_a = {2'h0, `DPC_PCM_CW, v[4:0]};
			end
		end
	endfunction

	// ------------------------------------------------------------
	// 12-8-12 coder, full eight-bit word
	// ------------------------------------------------------------
	function [7:0] code_b;
		input [11:0] mag;
		input        neg;
		input        nonpos;
		input [11:0] pix;
		reg   [11:0] v;
		begin
			v = 12'h000;
			// classes tried from narrowest to widest
			if (mag < `DPC_B_TH1) begin
				// zero counts as negative here, so no all-zero word
				code_b = {`DPC_B_CW1, nonpos, mag[2:0]};
			end else if (mag < `DPC_B_TH2) begin
				v = scale(mag, `DPC_B_TH1, `DPC_B_DIV2);
				code_b = {`DPC_B_CW2, neg, v[3:0]};
			end else if (mag < `DPC_B_TH3) begin
				v = scale(mag, `DPC_B_TH2, `DPC_B_DIV3);
				code_b = {`DPC_B_CW3, neg, v[3:0]};
			end else if (mag < `DPC_B_TH4) begin
				v = scale(mag, `DPC_B_TH3, `DPC_B_DIV4);
				code_b = {`DPC_B_CW4, neg, v[3:0]};
			end else if (mag < `DPC_B_TH5) begin
				v = scale(mag, `DPC_B_TH4, `DPC_B_DIV5);
				code_b = {`DPC_B_CW5, neg, v[2:0]};
			end else begin
				v = pix / `DPC_B_DIV_PCM;
				code_b = {`DPC_PCM_CW, v[6:0]};
			end
		end
	endfunction

	// ------------------------------------------------------------
	// 12-7-12 coder, seven bits in the low end of the word
	// ------------------------------------------------------------
	function [7:0] code_c;
		input [11:0] mag;
		input        neg;
		input        nonpos;
		input [11:0] pix;
		reg   [11:0] v;
		begin
			v = 12'h000;
			// classes tried from narrowest to widest
			if (mag < `DPC_C_TH1) begin
				code_c = {1'h0, `DPC_C_CW1, nonpos, mag[1:0]};
			end else if (mag < `DPC_C_TH2) begin
				v = scale(mag, `DPC_C_TH1, `DPC_C_DIV2);
				code_c = {1'h0, `DPC_C_CW2, neg, v[1:0]};
			end else if (mag < `DPC_C_TH3) begin
				v = scale(mag, `DPC_C_TH2, `DPC_C_DIV3);
				code_c = {1'h0, `DPC_C_CW3, neg, v[1:0]};
			end else if (mag < `DPC_C_TH4) begin
				v = scale(mag, `DPC_C_TH3, `DPC_C_DIV4);
				code_c = {1'h0, `DPC_C_CW4, neg, v[2:0]};
			end else if (mag < `DPC_C_TH5) begin
				v = scale(mag, `DPC_C_TH4, `DPC_C_DIV5);
				code_c = {1'h0, `DPC_C_CW5, neg, v[2:0]};
			end else if (mag < `DPC_C_TH6) begin
				v = scale(mag, `DPC_C_TH5, `DPC_C_DIV6);
				code_c = {1'h0, `DPC_C_CW6, neg, v[1:0]};
			end else begin
				v = pix / `DPC_C_DIV_PCM;
				code_c = {1'h0, `DPC_PCM_CW, v[5:0]};
			end
		end
	endfunction

	// ------------------------------------------------------------
	// input widening
	// ------------------------------------------------------------
	// 10-bit pixels sit in the low bits; upper bits are ignored
	wire [11:0] pix12;
	wire [11:0] pix10;
	wire [11:0] mag12;
	wire [11:0] mag10;
	wire [11:0] raw_a;
	wire [11:0] raw_b;
	wire [11:0] raw_c;

	assign pix12 = in_pixel[11:0];
	assign mag12 = abs_diff[11:0];
	assign pix10 = {2'h0, in_pixel[9:0]};
	assign raw_a = raw_code(pix10, `DPC_A_DIV_RAW);
	assign raw_b = raw_code(pix12, `DPC_B_DIV_RAW);
	assign raw_c = raw_code(pix12, `DPC_C_DIV_RAW);

	// difference for 10-bit pixels taken on the low ten bits only
	wire [10:0] diff10;
	wire        neg10;

	assign diff10 = {1'b0, in_pixel[9:0]} - {1'b0, in_pred[9:0]};
	assign neg10  = diff10[10];
	assign mag10  = neg10 ? {2'h0, (~diff10[9:0]) + 10'h001} : {2'h0, diff10[9:0]};

	// ------------------------------------------------------------
	// word selection
	// ------------------------------------------------------------
	reg [7:0] word_next;

	// the line's first pixel carries no prediction and is only scaled
	always @* begin
		word_next = 8'h00;
		case (mode)
			`DPC_MODE_10_6_10: begin
				if (in_unpredicted) begin
					word_next = {2'h0, raw_a[5:0]};
				end else begin
					word_next = code_a(mag10, neg10, pix10);
				end
			end
			`DPC_MODE_12_8_12: begin
				if (in_unpredicted) begin
					word_next = raw_b[7:0];
				end else begin
					word_next = code_b(mag12, diff_neg, diff_nonpos, pix12);
				end
			end
			`DPC_MODE_12_7_12: begin
				if (in_unpredicted) begin
					word_next = {1'h0, raw_c[6:0]};
				end else begin
					word_next = code_c(mag12, diff_neg, diff_nonpos, pix12);
				end
			end
			default: begin
				// unused mode code yields a zero word
				word_next = 8'h00;
			end
		endcase
	end

	// ------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------
	reg [7:0] word_reg;
	reg [1:0] mode_reg;
	reg       valid_reg;
	wire      take;

	// one stage holds a word; a new pixel enters as the old one leaves,
	// so a stalled packer stalls the pixel source the same cycle
	assign in_ready = ~valid_reg | out_ready;
	assign take     = in_valid & in_ready;

	// each accepted pixel becomes exactly one word, in arrival order
	always @(posedge clock) begin
		if (rst) begin
			valid_reg <= 1'b0;
			word_reg  <= 8'h00;
			mode_reg  <= 2'h0;
		end else begin
			if (take) begin
				valid_reg <= 1'b1;
				word_reg  <= word_next;
				mode_reg  <= mode;
			end else if (out_ready) begin
				valid_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// mode travels with the word so the packer knows its width
	assign out_valid = valid_reg;
	assign out_word  = word_reg[WORD_W-1:0];
	assign out_mode  = mode_reg;

endmodule

`default_nettype wire

// [dpc_sink_model.sv]
// downstream packer model: takes words at a chosen pace
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// sink
// ----------------------------------------
module dpc_sink_model (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [1:0] stall,
	output var  logic       out_ready
);
	logic [1:0] cnt_reg;
	logic       rst_seen;
	initial begin
		out_ready = 1'b0;
		cnt_reg = 2'h0;
	end
	// 0 always ready, 1 ready one cycle in three, 2 never; changes just after the edge
	// reset is read at the edge, before the bench moves it, so the two never race
	always @(posedge clock) begin
		rst_seen = rst;
		#1;
		cnt_reg = (cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
		out_ready = !rst_seen && (stall == 2'h0 || (stall == 2'h1 && cnt_reg == 2'h0));
	end
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the pixel compression encoder
`timescale 1ns/10ps
`default_nettype none
`include "dpc_consts.vh"

// ----------------------------------------
// bench
// ----------------------------------------
module tb_top;
	localparam logic [1:0] MA = `DPC_MODE_10_6_10;
	localparam logic [1:0] MB = `DPC_MODE_12_8_12;
	localparam logic [1:0] MC = `DPC_MODE_12_7_12;
	logic        clock, rst, in_valid, in_unpredicted, out_valid, out_ready, in_ready;
	logic [1:0]  mode, out_mode, stall;
	logic [11:0] in_pixel, in_pred;
	logic [7:0]  out_word;
	logic [9:0]  exp_q[$];
	logic [9:0]  exp_w;
	int          errors, comparisons;

	dpc_pixel_compressor uut (.clock(clock), .rst(rst), .mode(mode), .in_valid(in_valid),
		.in_ready(in_ready), .in_pixel(in_pixel), .in_pred(in_pred),
		.in_unpredicted(in_unpredicted), .out_valid(out_valid), .out_ready(out_ready),
		.out_word(out_word), .out_mode(out_mode));
	dpc_sink_model u_sink (.clock(clock), .rst(rst), .stall(stall), .out_ready(out_ready));

	always #5 clock = ~clock;

	// a hung handshake would otherwise stall the run forever
	initial begin
		#200us;
		errors++;
		tally_and_finish;
	end

	task automatic check_val(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// offer one pixel and hold it until the encoder accepts it
	task automatic px(input logic [1:0] m, input logic [11:0] p, input logic [11:0] q,
		input logic u, input logic [7:0] e);
		#1;
		mode = m;
		in_pixel = p;
		in_pred = q;
		in_unpredicted = u;
		in_valid = 1'b1;
		@(negedge clock);
		while (in_ready !== 1'b1) @(negedge clock);
		exp_q.push_back({m, e});
		@(posedge clock);
	endtask

	task automatic settle;
		int n;
		n = 0;
		#1;
		in_valid = 1'b0;
		while (exp_q.size() != 0 && n < 60) begin
			@(posedge clock);
			n++;
		end
		check_val("words_left", 8'(exp_q.size()), 8'h00);
	endtask

	// words are judged when the packer takes them, in order
	always @(negedge clock) begin
		if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
			exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h3FF;
			check_val("out_word", out_word, exp_w[7:0]);
			check_val("out_mode", {6'h00, out_mode}, {6'h00, exp_w[9:8]});
		end
	end

	task automatic test_a;
		px(MA, 12'h005, 12'h000, 1'b1, 8'h01);
		px(MA, 12'h3FF, 12'h000, 1'b1, 8'h3F);
		px(MA, 12'h064, 12'h064, 1'b0, 8'h01);
		px(MA, 12'h064, 12'h066, 1'b0, 8'h03);
		px(MA, 12'h05A, 12'h064, 1'b0, 8'h07);
		px(MA, 12'h08E, 12'h064, 1'b0, 8'h0B);
		px(MA, 12'h01E, 12'h0C8, 1'b0, 8'h1F);
		px(MA, 12'h10F, 12'h064, 1'b0, 8'h28);
		settle;
	endtask

	task automatic test_b;
		px(MB, 12'h00F, 12'h000, 1'b1, 8'h01);
		px(MB, 12'h1F4, 12'h1F4, 1'b0, 8'h08);
		px(MB, 12'h1ED, 12'h1F4, 1'b0, 8'h0F);
		px(MB, 12'h1CD, 12'h1F4, 1'b0, 8'h7F);
		px(MB, 12'h21C, 12'h1F4, 1'b0, 8'h40);
		px(MB, 12'h10D, 12'h1F4, 1'b0, 8'h3F);
		px(MB, 12'h2DC, 12'h1F4, 1'b0, 8'h10);
		px(MB, 12'h35C, 12'h1F4, 1'b0, 8'h9A);
		settle;
	endtask

	task automatic test_c;
		px(MC, 12'h01F, 12'h000, 1'b1, 8'h01);
		px(MC, 12'hFFF, 12'h000, 1'b1, 8'h7F);
		px(MC, 12'h1F4, 12'h1F4, 1'b0, 8'h04);
		px(MC, 12'h1F7, 12'h1F4, 1'b0, 8'h03);
		px(MC, 12'h1E9, 12'h1F4, 1'b0, 8'h0F);
		px(MC, 12'h34F, 12'h1F4, 1'b0, 8'h1B);
		px(MC, 12'h208, 12'h1F4, 1'b0, 8'h12);
		px(MC, 12'h1B8, 12'h1F4, 1'b0, 8'h2C);
		px(MC, 12'h2BC, 12'h1F4, 1'b0, 8'h36);
		px(MC, 12'h350, 12'h1F4, 1'b0, 8'h4D);
		settle;
	endtask

	// back to back pixels while the packer stalls two cycles in three
	task automatic test_stall;
		stall = 2'h1;
		px(MA, 12'h10F, 12'h064, 1'b0, 8'h28);
		px(2'h3, 12'h1F4, 12'h1F4, 1'b0, 8'h00);
		px(MB, 12'hFFF, 12'h000, 1'b1, 8'hFF);
		px(MC, 12'h350, 12'h1F4, 1'b0, 8'h4D);
		settle;
	endtask

	// a held word is dropped by a reset in mid-run
	task automatic test_reset;
		stall = 2'h2;
		px(MB, 12'h1F4, 12'h1F4, 1'b0, 8'h08);
		#1;
		in_valid = 1'b0;
		@(negedge clock);
		check_val("held_valid", {7'h00, out_valid}, 8'h01);
		check_val("stall_ready", {7'h00, in_ready}, 8'h00);
		@(posedge clock);
		#1;
		rst = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		exp_q.delete();
		@(negedge clock);
		check_val("reset_word", out_word, 8'h00);
		check_val("reset_mode", {6'h00, out_mode}, 8'h00);
		check_val("reset_ready", {6'h00, out_valid, in_ready}, 8'h01);
	endtask

	initial begin
		clock = 1'b0;
		rst = 1'b1;
		stall = 2'h0;
		mode = 2'h0;
		in_valid = 1'b0;
		in_pixel = 12'h000;
		in_pred = 12'h000;
		in_unpredicted = 1'b0;
		repeat (12) @(posedge clock);
		#1;
		rst = 1'b0;
		// let one edge pass so every pixel is driven the same 1 ns after its edge
		@(posedge clock);
		test_a;
		test_b;
		test_c;
		test_stall;
		test_reset;
		tally_and_finish;
	end
endmodule
`default_nettype wire
